// file: shared/aipl_consts.svh
// register offsets, field positions and reset values of the interrupt pin logic
`ifndef AIPL_CONSTS_SVH
`define AIPL_CONSTS_SVH

`define AIPL_ADR_STATUS 8'h00
`define AIPL_ADR_SECONDARY 8'h04
`define AIPL_ADR_DATA_X 8'h08
`define AIPL_ADR_DATA_Y 8'h0C
`define AIPL_ADR_DATA_Z 8'h10
`define AIPL_ADR_PIN_A_ROUTING 8'h14
`define AIPL_ADR_PIN_B_ROUTING 8'h18
`define AIPL_ADR_TIMING 8'h1C
`define AIPL_ADR_LINK_CFG 8'h20

`define AIPL_BIT_DRDY 0
`define AIPL_BIT_ACT 1
`define AIPL_BIT_STILLNESS_FLAG 2
`define AIPL_BIT_WARN 3
`define AIPL_BIT_LOW 7

`define AIPL_ROUTE_A_MASK 8'h87
`define AIPL_ROUTE_B_MASK 8'h8F
`define AIPL_ROUTE_RST 8'h00

`define AIPL_BIT_TRIG_SEL 0
`define AIPL_BIT_TB_SEL 1
`define AIPL_TIMING_MASK 8'h03
`define AIPL_TIMING_RST 8'h00

`define AIPL_BIT_LINK_DEFAULT 0
`define AIPL_BIT_ACT_TMR_ZERO 1
`define AIPL_BIT_STILLNESS_FLAG_TMR_ZERO 2
`define AIPL_LINK_MASK 8'h07
`define AIPL_LINK_RST 8'h01

`endif

// file: shared/aipl_pkg.sv
// types shared by the interrupt pin logic
package aipl_pkg;
    typedef enum logic [1:0] {st_idle, st_busy, st_answer} aipl_bus_state_type;
endpackage

// file: rtl/aipl_pin_drv.sv
// one interrupt pin: routing OR, polarity, tri-state with keeper, alternate input
`timescale 1ns/1ps
`include "aipl_consts.svh"
module aipl_pin_drv (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] flags,
    input wire logic [7:0] routing,
    input wire logic alt_sel,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe,
    output logic alt_level
);
    logic sync1_reg;
    logic sync2_reg;
    logic drive;
    logic level;

    assign drive = (|routing[3:0]) && !alt_sel;
    assign level = (|(flags & routing[3:0])) ^ routing[`AIPL_BIT_LOW];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= drive;
        end
    end

    // level frozen while released so the keeper sees the last valid state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_o <= 1'b0;
        end else if (drive) begin
            pin_o <= level;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
        end
    end

    // pin is released while used as input, so gate stops any stale level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alt_level <= 1'b0;
        end else begin
            alt_level <= alt_sel ? sync2_reg : 1'b0;
        end
    end
endmodule

// file: rtl/aipl_irq_logic.sv
// interrupt flags, routing registers, clear-on-read and pin control
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "aipl_consts.svh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// R01: each event routable to pin a, b, both, except motion warning (pin b only)
// R02: pin asserts on OR of routed events
// R03: pin with nothing routed goes high-Z
// R04: both pins high-Z after reset
// R05: active high, low-polarity bit makes active low
// R06: every event readable as a status flag
// R07: secondary read clears motion and stillness
// R08: default link, timer zero: only restart clears
// R09: secondary read always clears motion warning
// R10: data register read clears sample-ready
// R11: keeper holds last level while high-Z
// R12: host should mask events while configuring
// R13: timebase select turns pin a to input
// R14: trigger select turns pin b to input
// R15: both alternates allowed, no interrupts then
// R16: activity sets motion, inactivity sets stillness
// R17: sample-ready set by new data, cleared else
// R18: no sample-ready set during data read
// R19: set sample-ready cleared at read start
// R20: data during read sets flag at completion
// R21: motion warning routable to pin b only
// R22: polarity applied after the OR
module aipl_irq_logic (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic evt_activity,
    input wire logic evt_inactivity,
    input wire logic evt_motion_warn,
    input wire logic evt_new_data,
    input wire logic evt_measure_restart,
    input wire logic [11:0] accel_x,
    input wire logic [11:0] accel_y,
    input wire logic [11:0] accel_z,
    input wire logic irq_pin_a_i,
    output logic irq_pin_a_o,
    output logic irq_pin_a_oe,
    input wire logic irq_pin_b_i,
    output logic irq_pin_b_o,
    output logic irq_pin_b_oe,
    output logic ext_timebase,
    output logic ext_trigger
);
    //////////////////////////////////////////////////////////////////////////
    logic rst_s1_reg;
    logic rst_n;
    aipl_pkg::aipl_bus_state_type state_reg;
    logic [7:0] adr_reg;
    logic we_reg;
    logic sel0_reg;
    logic [31:0] wdat_reg;
    logic [7:0] pin_a_routing_reg;
    logic [7:0] pin_b_routing_reg;
    logic [7:0] timing_reg;
    logic [7:0] link_cfg_reg;
    logic motion_flag_reg;
    logic stillness_flag_reg;
    logic motion_warning_flag_reg;
    logic sample_ready_reg;
    logic in_data_rd_reg;
    logic pend_data_reg;
    logic [3:0] flag_vec;
    logic req, start, start_data_rd, done, wr_done, sec_clr;
    logic hold_motion, hold_still;
    logic [31:0] rdata;

    function automatic logic is_data(input logic [7:0] adr);
        is_data = (adr == `AIPL_ADR_DATA_X) || (adr == `AIPL_ADR_DATA_Y)
            || (adr == `AIPL_ADR_DATA_Z);
    endfunction

    function automatic logic [31:0] sext(input logic [11:0] v);
        sext = {{20{v[11]}}, v};
    endfunction

    // reset asserts at once, releases through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // bus slave: take, one busy cycle, answer
    assign req = wb_cyc_i && wb_stb_i;
    assign start = (state_reg == aipl_pkg::st_idle) && req;
    assign start_data_rd = start && !wb_we_i && is_data(wb_adr_i);
    assign done = (state_reg == aipl_pkg::st_answer);
    assign wr_done = done && we_reg && sel0_reg;
    assign sec_clr = done && !we_reg && (adr_reg == `AIPL_ADR_SECONDARY);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= aipl_pkg::st_idle;
        end else begin
            case (state_reg)
                aipl_pkg::st_idle: begin
                    if (req) begin
                        state_reg <= aipl_pkg::st_busy;
                    end
                end
                aipl_pkg::st_busy: state_reg <= aipl_pkg::st_answer;
                aipl_pkg::st_answer: state_reg <= aipl_pkg::st_idle;
                default: state_reg <= aipl_pkg::st_idle;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adr_reg <= 8'h00;
            we_reg <= 1'b0;
            sel0_reg <= 1'b0;
            wdat_reg <= 32'h00000000;
        end else if (start) begin
            adr_reg <= wb_adr_i;
            we_reg <= wb_we_i;
            sel0_reg <= wb_sel_i[0];
            wdat_reg <= wb_dat_i;
        end
    end

    assign flag_vec = {motion_warning_flag_reg, stillness_flag_reg, motion_flag_reg,
        sample_ready_reg};

    always_comb begin
        rdata = 32'h00000000;
        case (adr_reg)
            `AIPL_ADR_STATUS: rdata = {28'h0000000, flag_vec}; // see R06
            `AIPL_ADR_SECONDARY: rdata = {28'h0000000, flag_vec[3:1], 1'b0};
            `AIPL_ADR_DATA_X: rdata = sext(accel_x);
            `AIPL_ADR_DATA_Y: rdata = sext(accel_y);
            `AIPL_ADR_DATA_Z: rdata = sext(accel_z);
            `AIPL_ADR_PIN_A_ROUTING: rdata = {24'h000000, pin_a_routing_reg};
            `AIPL_ADR_PIN_B_ROUTING: rdata = {24'h000000, pin_b_routing_reg};
            `AIPL_ADR_TIMING: rdata = {24'h000000, timing_reg};
            `AIPL_ADR_LINK_CFG: rdata = {24'h000000, link_cfg_reg};
            default: rdata = 32'h00000000;
        endcase
    end

    // unmapped addresses still answer, reading zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= (state_reg == aipl_pkg::st_busy);
            if (state_reg == aipl_pkg::st_busy) begin
                wb_dat_o <= we_reg ? 32'h00000000 : rdata;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_a_routing_reg <= `AIPL_ROUTE_RST;
            pin_b_routing_reg <= `AIPL_ROUTE_RST;
            timing_reg <= `AIPL_TIMING_RST;
            link_cfg_reg <= `AIPL_LINK_RST;
        end else if (wr_done) begin
            case (adr_reg)
                // motion warning bit cannot stick in pin a
                `AIPL_ADR_PIN_A_ROUTING:
                    pin_a_routing_reg <= wdat_reg[7:0] & `AIPL_ROUTE_A_MASK; // see R21
                `AIPL_ADR_PIN_B_ROUTING:
                    pin_b_routing_reg <= wdat_reg[7:0] & `AIPL_ROUTE_B_MASK; // see R01
                `AIPL_ADR_TIMING: timing_reg <= wdat_reg[7:0] & `AIPL_TIMING_MASK;
                `AIPL_ADR_LINK_CFG: link_cfg_reg <= wdat_reg[7:0] & `AIPL_LINK_MASK;
                default: timing_reg <= timing_reg;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // event flags; a set in the clearing cycle wins, but new data at a data read's start sets sample-ready only at the read's end
    assign hold_motion = link_cfg_reg[`AIPL_BIT_LINK_DEFAULT]
        && link_cfg_reg[`AIPL_BIT_ACT_TMR_ZERO];
    assign hold_still = link_cfg_reg[`AIPL_BIT_LINK_DEFAULT]
        && link_cfg_reg[`AIPL_BIT_STILLNESS_FLAG_TMR_ZERO];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            motion_flag_reg <= 1'b0;
        end else if (evt_activity) begin
            motion_flag_reg <= 1'b1; // see R16
        end else if (evt_measure_restart || (sec_clr && !hold_motion)) begin
            motion_flag_reg <= 1'b0; // see R07 see R08
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stillness_flag_reg <= 1'b0;
        end else if (evt_inactivity) begin
            stillness_flag_reg <= 1'b1; // see R16
        end else if (evt_measure_restart || (sec_clr && !hold_still)) begin
            stillness_flag_reg <= 1'b0; // see R07 see R08
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            motion_warning_flag_reg <= 1'b0;
        end else if (evt_motion_warn) begin
            motion_warning_flag_reg <= 1'b1;
        end else if (sec_clr) begin
            motion_warning_flag_reg <= 1'b0; // see R09
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_data_rd_reg <= 1'b0;
        end else if (start_data_rd) begin
            in_data_rd_reg <= 1'b1;
        end else if (done) begin
            in_data_rd_reg <= 1'b0;
        end
    end

    // new data seen during a read waits here for the read's end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_data_reg <= 1'b0;
        end else if (in_data_rd_reg && done) begin
            pend_data_reg <= 1'b0;
        end else if (evt_new_data && (start_data_rd || in_data_rd_reg)) begin
            pend_data_reg <= 1'b1; // see R18
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_ready_reg <= 1'b0;
        end else if (start_data_rd) begin
            sample_ready_reg <= 1'b0; // see R10 see R19
        end else if (in_data_rd_reg && done) begin
            sample_ready_reg <= pend_data_reg || evt_new_data; // see R20
        end else if (in_data_rd_reg) begin
            sample_ready_reg <= 1'b0; // see R18
        end else if (evt_new_data) begin
            sample_ready_reg <= 1'b1; // see R17
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pins; alternates release the pin and pass the input on
    aipl_pin_drv u_pin_a (
        .clk(clk),
        .rst_n(rst_n),
        .flags(flag_vec),
        .routing(pin_a_routing_reg),
        .alt_sel(timing_reg[`AIPL_BIT_TB_SEL]), // see R13 see R15
        .pin_i(irq_pin_a_i),
        .pin_o(irq_pin_a_o), // see R02 see R05 see R22 see R11
        .pin_oe(irq_pin_a_oe), // see R03 see R04
        .alt_level(ext_timebase)
    );

    aipl_pin_drv u_pin_b (
        .clk(clk),
        .rst_n(rst_n),
        .flags(flag_vec),
        .routing(pin_b_routing_reg),
        .alt_sel(timing_reg[`AIPL_BIT_TRIG_SEL]), // see R14 see R15
        .pin_i(irq_pin_b_i),
        .pin_o(irq_pin_b_o),
        .pin_oe(irq_pin_b_oe),
        .alt_level(ext_trigger)
    );

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_or_polarity;
        (|pin_b_routing_reg[3:0]) && !timing_reg[`AIPL_BIT_TRIG_SEL] |=>
            irq_pin_b_oe && (irq_pin_b_o == ((|($past(flag_vec) & $past(pin_b_routing_reg[3:0])))
            ^ $past(pin_b_routing_reg[`AIPL_BIT_LOW])));
    endproperty
    a_or_polarity: assert property (p_or_polarity) else $error("pin b level wrong"); // see R02
    property p_low_active;
        (pin_a_routing_reg == 8'h81) && sample_ready_reg && !timing_reg[`AIPL_BIT_TB_SEL]
            |=> irq_pin_a_oe && !irq_pin_a_o;
    endproperty
    a_low_active: assert property (p_low_active) else $error("low polarity ignored"); // see R05
    property p_unrouted_z;
        pin_b_routing_reg[3:0] == 4'h0 |=> !irq_pin_b_oe;
    endproperty
    a_unrouted_z: assert property (p_unrouted_z) else $error("unrouted pin driven"); // see R03
    property p_reset_z;
        $rose(rst_n) |-> !irq_pin_a_oe && !irq_pin_b_oe;
    endproperty
    a_reset_z: assert property (p_reset_z) else $error("pin driven at reset"); // see R04
    property p_keeper;
        !irq_pin_a_oe |-> irq_pin_a_o == $past(irq_pin_a_o);
    endproperty
    a_keeper: assert property (p_keeper) else $error("released pin level moved"); // see R11
    property p_timebase_in;
        timing_reg[`AIPL_BIT_TB_SEL] |=> !irq_pin_a_oe;
    endproperty
    a_timebase_in: assert property (p_timebase_in) else $error("pin a driven as input"); // see R13
    property p_trigger_in;
        timing_reg[`AIPL_BIT_TRIG_SEL] |=> !irq_pin_b_oe;
    endproperty
    a_trigger_in: assert property (p_trigger_in) else $error("pin b driven as input"); // see R14
    property p_warn_clear;
        sec_clr && !evt_motion_warn |=> !motion_warning_flag_reg;
    endproperty
    a_warn_clear: assert property (p_warn_clear) else $error("warning not cleared"); // see R09
    property p_motion_clear;
        sec_clr && !hold_motion && !evt_activity |=> !motion_flag_reg;
    endproperty
    a_motion_clear: assert property (p_motion_clear) else $error("motion not cleared"); // see R07
    property p_motion_hold;
        motion_flag_reg && hold_motion && sec_clr && !evt_measure_restart |=> motion_flag_reg;
    endproperty
    a_motion_hold: assert property (p_motion_hold) else $error("held motion cleared"); // see R08
    property p_rd_start_clear;
        start_data_rd |=> !sample_ready_reg ##1 !sample_ready_reg;
    endproperty
    a_rd_start_clear: assert property (p_rd_start_clear) else $error("ready kept"); // see R19
    property p_rd_quiet;
        in_data_rd_reg |-> !sample_ready_reg;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("ready set in read"); // see R18
    property p_rd_late_set;
        in_data_rd_reg && done && pend_data_reg |=> sample_ready_reg;
    endproperty
    a_rd_late_set: assert property (p_rd_late_set) else $error("late data lost"); // see R20
    property p_warn_not_a;
        !pin_a_routing_reg[`AIPL_BIT_WARN];
    endproperty
    a_warn_not_a: assert property (p_warn_not_a) else $error("warning routed to a"); // see R21
    property p_status_read;
        (state_reg == aipl_pkg::st_busy) && !we_reg && (adr_reg == `AIPL_ADR_STATUS)
            |=> wb_ack_o && (wb_dat_o[3:0] == $past(flag_vec));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong"); // see R06
    property p_activity_set;
        evt_activity |=> motion_flag_reg;
    endproperty
    a_activity_set: assert property (p_activity_set) else $error("activity missed"); // see R16
    c_late_data: cover property (in_data_rd_reg && done && pend_data_reg);
    c_pin_b_low: cover property (irq_pin_b_oe && pin_b_routing_reg[`AIPL_BIT_LOW] && !irq_pin_b_o);
    c_both_alt: cover property (timing_reg == `AIPL_TIMING_MASK);
    c_sec_clear: cover property (sec_clr && motion_warning_flag_reg);
endmodule

// file: bench/aipl_host_model.sv
// host side of one interrupt pin: resolved wire level and alternate-input drive
`timescale 1ns/1ps
module aipl_host_model (
    input wire logic clk,
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic drv_en,
    input wire logic drv_level,
    output logic pin_level,
    output logic clash
);
    logic held_reg = 1'b0;
    // released wire keeps its last level, as the device keeper holds it
    always_comb begin
        if (pin_oe) begin
            pin_level = pin_o;
        end else if (drv_en) begin
            pin_level = drv_level;
        end else begin
            pin_level = held_reg;
        end
    end
    always_ff @(posedge clk) begin
        held_reg <= pin_level;
    end
    assign clash = pin_oe & drv_en;
endmodule

// file: bench/accel_interrupt_pin_logic_tb_top.sv
// self-checking bench of the interrupt pin logic
`timescale 1ns/1ps
`include "aipl_consts.svh"
module accel_interrupt_pin_logic_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic [31:0] dat_o;
    logic ack;
    logic ev_act = 1'b0;
    logic ev_stillness_flag = 1'b0;
    logic ev_warn = 1'b0;
    logic ev_new = 1'b0;
    logic ev_rst = 1'b0;
    logic [11:0] ax = 12'h800;
    logic [11:0] ay = 12'h0;
    logic [11:0] az = 12'h0;
    logic pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, ext_tb, ext_tr, a_clash, b_clash;
    logic a_en = 1'b0;
    logic a_lv = 1'b0;
    logic b_en = 1'b0;
    logic b_lv = 1'b0;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [3:0] f = 4'h0;
    logic [31:0] q;
    logic [7:0] ra, rb;
    logic [4:0] e;

    always #2.5 clk = ~clk;

    aipl_irq_logic u_dut (.clk(clk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .evt_activity(ev_act), .evt_inactivity(ev_stillness_flag),
        .evt_motion_warn(ev_warn), .evt_new_data(ev_new), .evt_measure_restart(ev_rst),
        .accel_x(ax), .accel_y(ay), .accel_z(az), .irq_pin_a_i(pa_i), .irq_pin_a_o(pa_o),
        .irq_pin_a_oe(pa_oe), .irq_pin_b_i(pb_i), .irq_pin_b_o(pb_o), .irq_pin_b_oe(pb_oe),
        .ext_timebase(ext_tb), .ext_trigger(ext_tr));
    aipl_host_model u_host_a (.clk(clk), .pin_o(pa_o), .pin_oe(pa_oe), .drv_en(a_en),
        .drv_level(a_lv), .pin_level(pa_i), .clash(a_clash));
    aipl_host_model u_host_b (.clk(clk), .pin_o(pb_o), .pin_oe(pb_oe), .drv_en(b_en),
        .drv_level(b_lv), .pin_level(pb_i), .clash(b_clash));

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("[ERR] %0t run too long", $time);
            conclude();
        end
    end

    task automatic chk_word(input logic [31:0] act, input logic [31:0] exp, input string what);
        n_checks++;
        if (act !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, act, exp);
        end
    endtask

    // expected {oe, o}: driven while anything routed, polarity after the OR
    function automatic logic [1:0] pin_exp(input logic [7:0] r, input logic [3:0] fl);
        return {|r[3:0], (|(r[3:0] & fl)) ^ r[7]};
    endfunction

    task automatic chk_pin(input logic oe, input logic o, input logic [1:0] exp,
        input string what);
        n_checks++;
        if (oe !== exp[1] || (exp[1] && o !== exp[0])) begin
            errors++;
            $display("[ERR] %0t %s pin %b%b exp %b", $time, what, oe, o, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        // no own limit: the run timeout ends a missing answer
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, 4'hF, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        wb(1'b0, a, 32'h0, 4'hF, r);
    endtask

    // e = {restart, warn, stillness, motion, ready}
    task automatic pulse(input logic [4:0] ev);
        @(posedge clk);
        {ev_rst, ev_warn, ev_stillness_flag, ev_act, ev_new} <= ev;
        @(posedge clk);
        {ev_rst, ev_warn, ev_stillness_flag, ev_act, ev_new} <= 5'h0;
        repeat (3) @(posedge clk);
        // a set in the restart cycle wins
        if (ev[4]) f[2:1] = 2'b00;
        f = f | ev[3:0];
    endtask

    initial begin
        void'($urandom(32'hbf027193));
        ay = 12'($urandom);
        az = 12'h7FF;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        chk_pin(pa_oe, pa_o, 2'b00, "reset a");
        chk_pin(pb_oe, pb_o, 2'b00, "reset b");
        rd(`AIPL_ADR_PIN_B_ROUTING, q);
        chk_word(q, 32'h0, "route b rst");
        rd(`AIPL_ADR_LINK_CFG, q);
        chk_word(q, 32'h1, "link rst");
        wr(`AIPL_ADR_PIN_A_ROUTING, 32'h8F);
        rd(`AIPL_ADR_PIN_A_ROUTING, q);
        chk_word(q, 32'h87, "warn never on a");
        wb(1'b1, `AIPL_ADR_PIN_B_ROUTING, 32'h0F, 4'h0, q);
        rd(`AIPL_ADR_PIN_B_ROUTING, q);
        chk_word(q, 32'h0, "sel off write");
        wr(8'h40, 32'hFF);
        rd(8'h40, q);
        chk_word(q, 32'h0, "unmapped");
        rd(`AIPL_ADR_DATA_X, q);
        chk_word(q, 32'hFFFFF800, "x sign");
        rd(`AIPL_ADR_DATA_Z, q);
        chk_word(q, 32'h7FF, "z");
        // routing changed only with all events idle
        for (int i = 0; i < 16; i++) begin
            ra = 8'($urandom) & `AIPL_ROUTE_A_MASK;
            rb = 8'($urandom) & `AIPL_ROUTE_B_MASK;
            wr(`AIPL_ADR_PIN_A_ROUTING, {24'h0, ra});
            wr(`AIPL_ADR_PIN_B_ROUTING, {24'h0, rb});
            e = {1'b0, 4'($urandom)};
            pulse(e);
            rd(`AIPL_ADR_STATUS, q);
            chk_word(q, {28'h0, f}, "status");
            chk_pin(pa_oe, pa_o, pin_exp(ra, f), "a");
            chk_pin(pb_oe, pb_o, pin_exp(rb, f), "b");
            rd(`AIPL_ADR_SECONDARY, q);
            chk_word(q, {28'h0, f[3:1], 1'b0}, "secondary");
            f[3:1] = 3'b000;
            rd(`AIPL_ADR_DATA_Y, q);
            chk_word(q, {{20{ay[11]}}, ay}, "y");
            f[0] = 1'b0;
            repeat (2) @(posedge clk);
            rd(`AIPL_ADR_STATUS, q);
            chk_word(q, 32'h0, "cleared");
            chk_pin(pb_oe, pb_o, pin_exp(rb, f), "b clr");
        end
        wr(`AIPL_ADR_PIN_B_ROUTING, 32'h0);
        wr(`AIPL_ADR_PIN_A_ROUTING, 32'h01);
        pulse(5'b00001);
        wr(`AIPL_ADR_PIN_A_ROUTING, 32'h00);
        repeat (2) @(posedge clk);
        chk_pin(pa_oe, pa_o, 2'b00, "a released");
        chk_word(32'(pa_o), 32'h1, "keeper");
        wr(`AIPL_ADR_PIN_A_ROUTING, 32'h01);
        fork
            rd(`AIPL_ADR_DATA_X, q);
            begin
                repeat (2) @(posedge clk);
                ev_new <= 1'b1;
                @(posedge clk);
                ev_new <= 1'b0;
            end
        join
        repeat (2) @(posedge clk);
        rd(`AIPL_ADR_STATUS, q);
        chk_word(q, 32'h1, "ready after read");
        wr(`AIPL_ADR_LINK_CFG, 32'h7);
        pulse(5'b01110);
        rd(`AIPL_ADR_SECONDARY, q);
        rd(`AIPL_ADR_STATUS, q);
        chk_word(q, 32'h7, "timer zero keeps both");
        pulse(5'b10000);
        rd(`AIPL_ADR_STATUS, q);
        chk_word(q, 32'h1, "restart clears");
        // timer-zero bits alone do not hold outside default linking
        wr(`AIPL_ADR_LINK_CFG, 32'h6);
        pulse(5'b00110);
        rd(`AIPL_ADR_SECONDARY, q);
        rd(`AIPL_ADR_STATUS, q);
        chk_word(q, 32'h1, "linked mode clears");
        wr(`AIPL_ADR_LINK_CFG, 32'h1);
        wr(`AIPL_ADR_TIMING, 32'h2);
        repeat (2) @(posedge clk);
        chk_word(32'(pa_oe), 32'h0, "a alt no drive");
        a_en <= 1'b1;
        a_lv <= 1'b1;
        repeat (5) @(posedge clk);
        chk_word(32'(ext_tb), 32'h1, "timebase hi");
        a_lv <= 1'b0;
        wr(`AIPL_ADR_TIMING, 32'h3);
        b_en <= 1'b1;
        b_lv <= 1'b1;
        repeat (5) @(posedge clk);
        chk_word(32'(ext_tb), 32'h0, "timebase lo");
        chk_word(32'(ext_tr), 32'h1, "trigger");
        chk_word(32'({a_clash, b_clash}), 32'h0, "no clash");
        a_en <= 1'b0;
        b_en <= 1'b0;
        wr(`AIPL_ADR_TIMING, 32'h0);
        repeat (2) @(posedge clk);
        chk_word(32'(ext_tr), 32'h0, "trigger off");
        chk_pin(pa_oe, pa_o, 2'b11, "a back");
        wr(`AIPL_ADR_PIN_A_ROUTING, 32'h81);
        @(posedge clk);
        chk_pin(pa_oe, pa_o, 2'b10, "a low active");
        conclude();
    end
endmodule
